// ---- verilog/bcx_exec_regs.vh ----
// register map, command fields and codes of the bcd/bit/loop execution unit
`ifndef BCX_EXEC_REGS_VH
`define BCX_EXEC_REGS_VH

// register byte offsets
`define BCX_REG_CMD      8'h00
`define BCX_REG_FLAGS    8'h04
`define BCX_REG_OPA      8'h08
`define BCX_REG_OPB      8'h0C
`define BCX_REG_PC       8'h10
`define BCX_REG_RES_LO   8'h14
`define BCX_REG_RES_HI   8'h18
`define BCX_REG_TARGET   8'h1C
`define BCX_REG_STATUS   8'h20
`define BCX_REG_ADDR0    8'h24
`define BCX_REG_ADDR1    8'h28
`define BCX_REG_COUNT    8'h2C
`define BCX_REG_ACC_LO   8'h30
`define BCX_REG_ACC_HI   8'h34

// command word fields
`define BCX_F_OP         4:0
`define BCX_F_WORD       5
`define BCX_F_TO_CARRY   6
`define BCX_F_COND       11:8
`define BCX_F_IMM        15:12
`define BCX_F_BIT        19:16
`define BCX_F_DISP       31:24

// flag register bit positions
`define BCX_FL_C         0
`define BCX_FL_Z         1
`define BCX_FL_S         2
`define BCX_FL_O         3

// status register bit positions
`define BCX_ST_BUSY      0
`define BCX_ST_BRANCH    1
`define BCX_ST_OVF       2
`define BCX_ST_SUSP      3
`define BCX_ST_DONE      4

// operation codes
`define BCX_OP_BCD_ADD   5'h00
`define BCX_OP_BCD_ADC   5'h01
`define BCX_OP_BCD_SUB   5'h02
`define BCX_OP_BCD_SBB   5'h03
`define BCX_OP_ADD_LOOP  5'h04
`define BCX_OP_SUB_LOOP  5'h05
`define BCX_OP_MAC       5'h06
`define BCX_OP_SEXT      5'h07
`define BCX_OP_BIT_AND   5'h08
`define BCX_OP_BIT_NAND  5'h09
`define BCX_OP_BIT_OR    5'h0A
`define BCX_OP_BIT_NOR   5'h0B
`define BCX_OP_BIT_XOR   5'h0C
`define BCX_OP_BIT_NXOR  5'h0D
`define BCX_OP_COND_BIT  5'h0E
`define BCX_OP_IND_JUMP  5'h0F

// loop branch offset from the instruction start
`define BCX_LOOP_BIAS    20'h00002
// axi responses
`define BCX_RESP_OKAY    2'h0
`define BCX_RESP_SLVERR  2'h2

`endif

// ---- verilog/bcx_exec_unit.v ----
// bcd, loop-branch, sum-of-products, bit and indirect jump execution unit
//
// Functional notes
// - bcd add ignores incoming carry
// - bcd add with carry adds carry too
// - bcd adds update only S, Z, C
// - bcd subtract ignores borrow in carry
// - bcd subtract with borrow subtracts carry
// - bcd subtracts update only S, Z, C
// - add loop: signed -8..+7, branch if nonzero
// - subtract loop: -7..+8, branch if nonzero
// - loop target -126..+129 from instruction start
// - mac reads addr0, addr1, repeats count times
// - byte mac result only in low register
// - mac overflow sets O, stops, interrupts
// - interrupt waits for add and decrement
// - interrupt suspends mac mid-way
// - sign extend 8->16, word 16->32 pair
// - bit and/or, true or inverted, into carry
// - bit xor, true or inverted, into carry
// - conditional bit write: 1 if true
// - signed conditions from S xor O
// - word jump: start plus signed 16-bit
// - address jump: 20-bit absolute target
`timescale 1ns/1ps
`default_nettype none
`include "bcx_exec_regs.vh"

module bcx_exec_unit #(
  parameter ADDR_W = 8
) (
  // clock, reset, enable
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              ce,
  // axi4-lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // memory operand path
  output reg               mem_req,
  output reg  [19:0]       mem_addr,
  output reg               mem_word,
  input  wire              mem_ack,
  input  wire [15:0]       mem_rdata,
  // interrupt side
  input  wire              irq_request,
  output reg               irq_accept,
  output reg               overflow_interrupt
);

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_EXEC = 5'b00010;
  localparam [4:0] ST_RD0  = 5'b00100;
  localparam [4:0] ST_RD1  = 5'b01000;
  localparam [4:0] ST_ACC  = 5'b10000;

  reg  [4:0]  state;
  reg  [31:0] cmd;
  reg  [3:0]  flags;
  reg  [15:0] opa;
  reg  [15:0] opb;
  reg  [19:0] pc;
  reg  [31:0] res;
  reg  [19:0] target;
  reg         branch;
  reg         ovf_stop;
  reg         suspended;
  reg         done;
  reg  [19:0] addr0;
  reg  [19:0] addr1;
  reg  [15:0] count;
  reg  [15:0] acc_lo;
  reg  [15:0] acc_hi;
  reg  [15:0] mcand;
  reg  [15:0] mplier;
  reg         aw_got;
  reg         w_got;
  reg  [ADDR_W-1:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  // combinational results of a single-step command
  reg  [31:0] next_res;
  reg  [3:0]  next_flags;
  reg  [19:0] next_target;
  reg         next_branch;
  reg  [15:0] next_acc_hi;
  reg  [16:0] bsum;
  reg  [15:0] lval;
  reg  [15:0] step;
  reg         bitv;
  reg         cv;

  wire [4:0]  op    = cmd[`BCX_F_OP];
  wire        wsz   = cmd[`BCX_F_WORD];
  wire [3:0]  imm   = cmd[`BCX_F_IMM];
  wire [3:0]  bsel  = cmd[`BCX_F_BIT];
  wire        fc    = flags[`BCX_FL_C];

  // packed bcd add or subtract; bit 16 is the carry or borrow out
  function [16:0] bcd_calc;
    input [15:0] a;
    input [15:0] b;
    input        cin;
    input        sub;
    input        word;
    integer      i;
    reg   [4:0]  t;
    reg          c;
    reg          cbyte;
    reg   [15:0] r;
    begin
      c = cin;
      cbyte = 1'b0;
      r = 16'h0000;
      for (i = 0; i < 4; i = i + 1) begin
        if (sub) begin
          t = {1'b0, a[4*i +: 4]} - {1'b0, b[4*i +: 4]} - {4'h0, c};
          c = t[4];
          if (c)
            t = t - 5'h06;
        end else begin
          t = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
          c = (t > 5'h09);
          if (c)
            t = t + 5'h06;
        end
        r[4*i +: 4] = t[3:0];
        if (i == 1)
          cbyte = c;
      end
      if (word)
        bcd_calc = {c, r};
      else
        bcd_calc = {cbyte, 8'h00, r[7:0]};
    end
  endfunction

  // sign and zero of a byte or word result
  function [1:0] sign_zero;
    input [15:0] r;
    input        word;
    begin
      if (word)
        sign_zero = {r[15], r == 16'h0000};
      else
        sign_zero = {r[7], r[7:0] == 8'h00};
    end
  endfunction

  // fourteen flag conditions
  function cond_true;
    input [3:0] sel;
    input [3:0] f;
    reg         c;
    reg         z;
    reg         s;
    reg         o;
    reg         lt;
    begin
      c = f[`BCX_FL_C];
      z = f[`BCX_FL_Z];
      s = f[`BCX_FL_S];
      o = f[`BCX_FL_O];
      lt = s ^ o;
      case (sel)
        4'h0: cond_true = c;
        4'h1: cond_true = c & ~z;
        4'h2: cond_true = z;
        4'h3: cond_true = s;
        4'h4: cond_true = ~c;
        4'h5: cond_true = ~c | z;
        4'h6: cond_true = ~z;
        4'h7: cond_true = ~s;
        4'h8: cond_true = lt | z;
        4'h9: cond_true = o;
        4'hA: cond_true = ~lt;
        4'hB: cond_true = ~(lt | z);
        4'hC: cond_true = ~o;
        4'hD: cond_true = lt;
        default: cond_true = 1'b0;
      endcase
    end
  endfunction

  // single-step command datapath
  always @* begin
    next_res = res;
    next_flags = flags;
    next_target = target;
    next_branch = 1'b0;
    next_acc_hi = acc_hi;
    bsum = 17'h00000;
    lval = 16'h0000;
    step = 16'h0000;
    bitv = opb[bsel];
    cv = cond_true(cmd[`BCX_F_COND], flags);
    case (op)
      `BCX_OP_BCD_ADD, `BCX_OP_BCD_ADC: begin
        bsum = bcd_calc(opa, opb, (op == `BCX_OP_BCD_ADC) & fc,
                        1'b0, wsz);
        next_res = {16'h0000, bsum[15:0]};
        next_flags[`BCX_FL_C] = bsum[16];
        {next_flags[`BCX_FL_S], next_flags[`BCX_FL_Z]} =
          sign_zero(bsum[15:0], wsz);
      end
      `BCX_OP_BCD_SUB, `BCX_OP_BCD_SBB: begin
        bsum = bcd_calc(opa, opb, (op == `BCX_OP_BCD_SBB) & fc,
                        1'b1, wsz);
        next_res = {16'h0000, bsum[15:0]};
        next_flags[`BCX_FL_C] = bsum[16];
        {next_flags[`BCX_FL_S], next_flags[`BCX_FL_Z]} =
          sign_zero(bsum[15:0], wsz);
      end
      `BCX_OP_ADD_LOOP, `BCX_OP_SUB_LOOP: begin
        if (op == `BCX_OP_ADD_LOOP) begin
          step = {{12{imm[3]}}, imm};
          lval = opa + step;
        end else begin
          step = (imm <= 4'h8) ? {12'h000, imm} : {12'hFFF, imm};
          lval = opa - step;
        end
        if (!wsz)
          lval = {8'h00, lval[7:0]};
        next_res = {16'h0000, lval};
        next_branch = (lval != 16'h0000);
        next_target = pc + `BCX_LOOP_BIAS
                      + {{12{cmd[31]}}, cmd[`BCX_F_DISP]};
      end
      `BCX_OP_SEXT: begin
        if (wsz) begin
          next_acc_hi = {16{acc_lo[15]}};
          next_res = {{16{acc_lo[15]}}, acc_lo};
        end else begin
          next_res = {16'h0000, {8{opa[7]}}, opa[7:0]};
        end
      end
      `BCX_OP_BIT_AND:  next_flags[`BCX_FL_C] = fc & bitv;
      `BCX_OP_BIT_NAND: next_flags[`BCX_FL_C] = fc & ~bitv;
      `BCX_OP_BIT_OR:   next_flags[`BCX_FL_C] = fc | bitv;
      `BCX_OP_BIT_NOR:  next_flags[`BCX_FL_C] = fc | ~bitv;
      `BCX_OP_BIT_XOR:  next_flags[`BCX_FL_C] = fc ^ bitv;
      `BCX_OP_BIT_NXOR: next_flags[`BCX_FL_C] = fc ^ ~bitv;
      `BCX_OP_COND_BIT: begin
        if (cmd[`BCX_F_TO_CARRY]) begin
          next_flags[`BCX_FL_C] = cv;
        end else begin
          lval = opa;
          lval[bsel] = cv;
          next_res = {16'h0000, lval};
        end
      end
      `BCX_OP_IND_JUMP: begin
        next_branch = 1'b1;
        if (wsz)
          next_target = pc + {{4{opb[15]}}, opb};
        else
          next_target = {opa[3:0], opb};
      end
      default: ;
    endcase
  end

  // multiply-accumulate step: signed product into a 33-bit sum
  wire signed [31:0] prod_w = $signed(mcand) * $signed(mplier);
  wire signed [15:0] prod_b = $signed(mcand[7:0]) * $signed(mplier[7:0]);
  wire [32:0] acc_ext = wsz ? {acc_hi[15], acc_hi, acc_lo}
                            : {{17{acc_lo[15]}}, acc_lo};
  wire [32:0] prod_ext = wsz ? {prod_w[31], prod_w}
                             : {{17{prod_b[15]}}, prod_b};
  wire [32:0] mac_sum = acc_ext + prod_ext;
  wire        mac_ovf = wsz ? (mac_sum[32] ^ mac_sum[31])
                            : (mac_sum[16] ^ mac_sum[15]);
  wire [19:0] mac_stride = wsz ? 20'h00002 : 20'h00001;
  wire [15:0] count_dec = count - 16'h0001;

  // axi handshakes
  wire busy = ~state[0];
  assign s_axi_awready = ~aw_got & ~s_axi_bvalid & ce;
  assign s_axi_wready  = ~w_got & ~s_axi_bvalid & ce;
  assign s_axi_arready = ~s_axi_rvalid & ce;
  wire aw_now = aw_got | (s_axi_awvalid & s_axi_awready);
  wire w_now  = w_got | (s_axi_wvalid & s_axi_wready);
  wire [ADDR_W-1:0] wa = aw_got ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_got ? w_data : s_axi_wdata;
  wire [3:0]  ws = w_got ? w_strb : s_axi_wstrb;
  wire [31:0] bm = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire [31:0] bd = wd & bm;
  wire do_wr = aw_now & w_now & ~s_axi_bvalid;
  wire [7:0]  wa8 = {wa[7:2], 2'b00};
  wire [7:0]  ra8 = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] status = {27'h0, done, suspended, ovf_stop, branch, busy};

  reg [31:0] rd_val;
  reg        rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (ra8)
      `BCX_REG_CMD:    rd_val = cmd;
      `BCX_REG_FLAGS:  rd_val = {28'h0, flags};
      `BCX_REG_OPA:    rd_val = {16'h0, opa};
      `BCX_REG_OPB:    rd_val = {16'h0, opb};
      `BCX_REG_PC:     rd_val = {12'h0, pc};
      `BCX_REG_RES_LO: rd_val = {16'h0, res[15:0]};
      `BCX_REG_RES_HI: rd_val = {16'h0, res[31:16]};
      `BCX_REG_TARGET: rd_val = {12'h0, target};
      `BCX_REG_STATUS: rd_val = status;
      `BCX_REG_ADDR0:  rd_val = {12'h0, addr0};
      `BCX_REG_ADDR1:  rd_val = {12'h0, addr1};
      `BCX_REG_COUNT:  rd_val = {16'h0, count};
      `BCX_REG_ACC_LO: rd_val = {16'h0, acc_lo};
      `BCX_REG_ACC_HI: rd_val = {16'h0, acc_hi};
      default: begin
        rd_val = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  // software writes land only while idle; a command write also starts
  wire sw_ok = do_wr & ~busy;
  wire sw_hit = (wa8 <= `BCX_REG_ACC_HI) & (wa8 != `BCX_REG_RES_LO)
              & (wa8 != `BCX_REG_RES_HI) & (wa8 != `BCX_REG_TARGET)
              & (wa8 != `BCX_REG_STATUS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      cmd <= 32'h0;
      flags <= 4'h0;
      opa <= 16'h0;
      opb <= 16'h0;
      pc <= 20'h0;
      res <= 32'h0;
      target <= 20'h0;
      branch <= 1'b0;
      ovf_stop <= 1'b0;
      suspended <= 1'b0;
      done <= 1'b0;
      addr0 <= 20'h0;
      addr1 <= 20'h0;
      count <= 16'h0;
      acc_lo <= 16'h0;
      acc_hi <= 16'h0;
      mcand <= 16'h0;
      mplier <= 16'h0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BCX_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `BCX_RESP_OKAY;
      s_axi_rdata <= 32'h0;
      mem_req <= 1'b0;
      mem_addr <= 20'h0;
      mem_word <= 1'b0;
      irq_accept <= 1'b0;
      overflow_interrupt <= 1'b0;
    end else if (ce) begin
      irq_accept <= 1'b0;
      overflow_interrupt <= 1'b0;
      // write channels, either order
      if (s_axi_awvalid & s_axi_awready & ~w_now) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~aw_now) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= sw_hit ? `BCX_RESP_OKAY : `BCX_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `BCX_RESP_OKAY : `BCX_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (sw_ok) begin
        case (wa8)
          `BCX_REG_CMD: begin
            cmd <= cmd & ~bm | bd;
            state <= ST_EXEC;
            branch <= 1'b0;
            ovf_stop <= 1'b0;
            suspended <= 1'b0;
            done <= 1'b0;
          end
          `BCX_REG_FLAGS:  flags <= flags & ~bm[3:0] | bd[3:0];
          `BCX_REG_OPA:    opa <= opa & ~bm[15:0] | bd[15:0];
          `BCX_REG_OPB:    opb <= opb & ~bm[15:0] | bd[15:0];
          `BCX_REG_PC:     pc <= pc & ~bm[19:0] | bd[19:0];
          `BCX_REG_ADDR0:  addr0 <= addr0 & ~bm[19:0] | bd[19:0];
          `BCX_REG_ADDR1:  addr1 <= addr1 & ~bm[19:0] | bd[19:0];
          `BCX_REG_COUNT:  count <= count & ~bm[15:0] | bd[15:0];
          `BCX_REG_ACC_LO: acc_lo <= acc_lo & ~bm[15:0] | bd[15:0];
          `BCX_REG_ACC_HI: acc_hi <= acc_hi & ~bm[15:0] | bd[15:0];
          default: ;
        endcase
      end
      case (state)
        ST_IDLE: ;
        ST_EXEC: begin
          if (op == `BCX_OP_MAC) begin
            if (count == 16'h0000) begin
              done <= 1'b1;
              state <= ST_IDLE;
            end else begin
              mem_req <= 1'b1;
              mem_addr <= addr0;
              mem_word <= wsz;
              state <= ST_RD0;
            end
          end else begin
            res <= next_res;
            flags <= next_flags;
            target <= next_target;
            branch <= next_branch;
            acc_hi <= next_acc_hi;
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_RD0: if (mem_ack) begin
          mcand <= mem_rdata;
          mem_addr <= addr1;
          state <= ST_RD1;
        end
        ST_RD1: if (mem_ack) begin
          mplier <= mem_rdata;
          mem_req <= 1'b0;
          state <= ST_ACC;
        end
        ST_ACC: begin
          if (mac_ovf) begin
            flags[`BCX_FL_O] <= 1'b1;
            overflow_interrupt <= 1'b1;
            ovf_stop <= 1'b1;
            done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            acc_lo <= mac_sum[15:0];
            if (wsz)
              acc_hi <= mac_sum[31:16];
            addr0 <= addr0 + mac_stride;
            addr1 <= addr1 + mac_stride;
            count <= count_dec;
            if (count_dec == 16'h0000) begin
              done <= 1'b1;
              state <= ST_IDLE;
            end else if (irq_request) begin
              irq_accept <= 1'b1;
              suspended <= 1'b1;
              state <= ST_IDLE;
            end else begin
              mem_req <= 1'b1;
              mem_addr <= addr0 + mac_stride;
              state <= ST_RD0;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- tb/bcx_exec_checker.sv ----
// handshake, memory request and event pulse checks of the execution unit
`timescale 1ns/1ps
`default_nettype none
module bcx_exec_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // memory operand path and events
  input wire logic        mem_req,
  input wire logic [19:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        irq_request,
  input wire logic        irq_accept,
  input wire logic        overflow_interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid; endproperty
  a_bans: assert property (p_bans) else $error("no write response");
  property p_blow; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_blow: assert property (p_blow) else $error("write response repeated");
  property p_wref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wref: assert property (p_wref) else $error("write taken during response");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("no read response");
  property p_rlow; s_axi_rvalid |-> !s_axi_arready and
    (s_axi_rready |=> !s_axi_rvalid); endproperty
  a_rlow: assert property (p_rlow) else $error("read response misbehaves");
  property p_ovf; overflow_interrupt |=> !overflow_interrupt; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow pulse too long");
  property p_irq; irq_accept |-> $past(irq_request) ##1 !irq_accept;
  endproperty
  a_irq: assert property (p_irq) else $error("bad interrupt accept");
  property p_mem; mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
  endproperty
  a_mem: assert property (p_mem) else $error("operand request dropped");
endmodule
bind bcx_exec_unit bcx_exec_checker bcx_exec_checker_inst (.*);
`default_nettype wire

// ---- tb/test_bcx_exec_unit.sv ----
// self-checking bench of the bcd, loop, bit, mac and jump unit
`timescale 1ns/1ps
`default_nettype none
`include "bcx_exec_regs.vh"
module test_bcx_exec_unit;
  logic        aclk = 0, aresetn = 0, irq_request = 0, mem_ack = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [15:0] mem_rdata = 0;
  logic [31:0] wdata = 0, seed = 32'h6FD518C3, mv, rdata, rv, st;
  logic [31:0] a, b, f, e, t, cmd, v;
  logic [1:0]  bresp, rresp, bs, ev = 0;
  logic        awready, wready, bvalid, arready, rvalid, mem_req, mem_word;
  logic        irq_accept, overflow_interrupt, c;
  logic [19:0] mem_addr;
  logic [3:0]  im, k;
  logic [15:0] q[$];
  int          n_mismatch = 0, tests_run = 0, cycles = 0, i;
  always #10 aclk = ~aclk;
  bcx_exec_unit #(.ADDR_W(8)) bcx_exec_unit_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_word(mem_word), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .irq_request(irq_request),
    .irq_accept(irq_accept), .overflow_interrupt(overflow_interrupt));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] rbcd();
    logic [31:0] r;
    r = 0;
    for (int j = 0; j < 4; j++) r[j*4+:4] = 4'(rnd() % 10);
    return r;
  endfunction
  // digit-serial decimal reference, carry out in bit 16
  function automatic logic [16:0] bcd(logic [15:0] x, y, logic ci, sb, wd);
    logic [16:0] r;
    logic [4:0]  d;
    r = 0;
    for (int j = 0; j < (wd ? 4 : 2); j++) begin
      d = sb ? x[j*4+:4] - y[j*4+:4] - ci : x[j*4+:4] + y[j*4+:4] + ci;
      ci = sb ? d[4] : d > 9;
      if (ci) d = sb ? d + 10 : d - 10;
      r[j*4+:4] = d[3:0];
    end
    r[16] = ci;
    return r;
  endfunction
  function automatic logic cnd(logic [3:0] n, logic [3:0] fl);
    logic lt;
    lt = fl[2] ^ fl[3];
    case (n)
      0: return fl[0];
      1: return fl[0] & ~fl[1];
      2: return fl[1];
      3: return fl[2];
      4: return ~fl[0];
      5: return ~fl[0] | fl[1];
      6: return ~fl[1];
      7: return ~fl[2];
      8: return lt | fl[1];
      9: return fl[3];
      10: return ~lt;
      11: return ~(lt | fl[1]);
      12: return ~fl[3];
      13: return lt;
      default: return 1'b0;
    endcase
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    ev <= ev | {irq_accept, overflow_interrupt};
    if (cycles == 40000) begin
      n_mismatch++;
      close_out();
    end
  end
  // operand memory with stalls, small positive data
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    if (mem_req && !mem_ack && (cycles % 3) != 0) begin
      mv = rnd();
      mem_ack <= 1'b1;
      mem_rdata <= {12'h0, 1'b1, mv[2:0]};
      q.push_back({12'h0, 1'b1, mv[2:0]});
    end
  end
  // negedge sampling sees what the next rising edge takes
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      bs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    logic ta, tr;
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask
  task automatic op(input logic [31:0] cw);
    wr(`BCX_REG_CMD, cw);
    do rd(`BCX_REG_STATUS, st); while (st[`BCX_ST_BUSY] !== 1'b0);
  endtask
  task automatic mac(input logic [31:0] acc, cnt);
    wr(`BCX_REG_ADDR0, 32'h1000);
    wr(`BCX_REG_ADDR1, 32'h2000);
    wr(`BCX_REG_COUNT, cnt);
    wr(`BCX_REG_ACC_LO, acc);
    wr(`BCX_REG_ACC_HI, 32'h1234);
    wr(`BCX_REG_FLAGS, 0);
    q.delete();
    op(32'h06);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`BCX_REG_STATUS, rv);
    cmp("status", 0, rv);
    wr(8'h3C, 0);
    cmp("unmapped", `BCX_RESP_SLVERR, bs);
    wr(`BCX_REG_RES_LO, 0);
    cmp("read-only", `BCX_RESP_SLVERR, bs);
    for (i = 0; i < 32; i++) begin
      k = i % 4;
      a = (i < 4) ? 32'h9999 : (i < 8) ? 0 : rbcd();
      b = (i < 8) ? 1 : rbcd();
      f = rnd();
      wr(`BCX_REG_OPA, a);
      wr(`BCX_REG_OPB, b);
      wr(`BCX_REG_FLAGS, f);
      op({26'h0, i[2], 1'b0, k});
      e = bcd(a[15:0], b[15:0], k[0] & f[0], k[1], i[2]);
      rd(`BCX_REG_RES_LO, rv);
      cmp("bcd", {16'h0, e[15:0]}, rv);
      rd(`BCX_REG_FLAGS, rv);
      t = {28'h0, f[3], i[2] ? e[15] : e[7], e[15:0] == 0, e[16]};
      cmp("bcd flags", t, rv);
    end
    $display("bcd done");
    for (i = 0; i < 8; i++) begin
      im = rnd();
      cmd = rnd();
      t = rnd() & 32'hFFFFF;
      v = i[0] ? (im > 8 ? {28'hFFFFFFF, im} : {28'h0, im}) : {{28{im[3]}}, im};
      a = ((i < 4) ? (i[0] ? v : -v) : rnd()) & 32'hFFFF;
      wr(`BCX_REG_OPA, a);
      wr(`BCX_REG_PC, t);
      op({cmd[31:24], 8'h0, im, 4'h0, 3'h1, 4'h2, i[0]});
      e = (i[0] ? a - v : a + v) & 32'hFFFF;
      b = (t + 2 + {{24{cmd[31]}}, cmd[31:24]}) & 32'hFFFFF;
      rd(`BCX_REG_RES_LO, rv);
      cmp("loop value", e, rv);
      cmp("loop branch", {31'h0, e != 0}, {31'h0, st[1]});
      rd(`BCX_REG_TARGET, rv);
      if (e != 0) cmp("loop target", b, rv);
    end
    $display("loop done");
    for (i = 0; i < 24; i++) begin
      k = 8 + i % 6;
      a = rnd();
      f = rnd();
      im = rnd();
      wr(`BCX_REG_OPB, a);
      wr(`BCX_REG_FLAGS, f);
      op({12'h0, im, 12'h0, k});
      c = a[im] ^ k[0];
      c = (k < 10) ? c & f[0] : (k < 12) ? c | f[0] : c ^ f[0];
      rd(`BCX_REG_FLAGS, rv);
      cmp("bit carry", {28'h0, f[3:1], c}, rv);
    end
    $display("bit done");
    for (i = 0; i < 28; i++) begin
      im = i % 14;
      f = rnd();
      a = rnd() & 32'hFFFF;
      t = rnd();
      wr(`BCX_REG_OPA, a);
      wr(`BCX_REG_FLAGS, f);
      op({12'h0, t[3:0], 4'h0, im, 1'b0, i < 14, i >= 14, 5'h0E});
      c = cnd(im, f[3:0]);
      e = a;
      e[t[3:0]] = c;
      rd(i < 14 ? `BCX_REG_FLAGS : `BCX_REG_RES_LO, rv);
      cmp("cond", i < 14 ? {28'h0, f[3:1], c} : e, rv);
    end
    $display("cond done");
    for (i = 0; i < 4; i++) begin
      b = (i == 0) ? 32'h8000 : rnd() & 32'hFFFF;
      t = rnd() & 32'hFFFFF;
      wr(`BCX_REG_OPB, b);
      wr(`BCX_REG_PC, t);
      op(i[0] ? 32'h0F : 32'h2F);
      e = i[0] ? {a[3:0], b[15:0]} : (t + {{16{b[15]}}, b[15:0]}) & 32'hFFFFF;
      rd(`BCX_REG_TARGET, rv);
      cmp("jump", e, rv);
    end
    wr(`BCX_REG_OPA, 32'h80);
    op(32'h07);
    rd(`BCX_REG_RES_LO, rv);
    cmp("sext", 32'hFF80, rv);
    wr(`BCX_REG_ACC_LO, 32'h8001);
    op(32'h27);
    rd(`BCX_REG_ACC_HI, rv);
    cmp("sext hi", 32'hFFFF, rv);
    $display("jump done");
    mac(32'h10, 3);
    rd(`BCX_REG_ACC_LO, rv);
    cmp("mac", 32'h10 + q[0] * q[1] + q[2] * q[3] + q[4] * q[5], rv);
    rd(`BCX_REG_ACC_HI, rv);
    cmp("mac high", 32'h1234, rv);
    rd(`BCX_REG_ADDR1, rv);
    cmp("mac addr", 32'h2003, rv);
    mac(32'h7FF0, 2);
    cmp("ovf stop", 1, {31'h0, st[`BCX_ST_OVF]});
    rd(`BCX_REG_ACC_LO, rv);
    cmp("ovf acc", 32'h7FF0, rv);
    rd(`BCX_REG_FLAGS, rv);
    cmp("ovf flag", 1, {31'h0, rv[`BCX_FL_O]});
    cmp("ovf int", 1, ev);
    irq_request <= 1'b1;
    mac(0, 5);
    irq_request <= 1'b0;
    cmp("suspend", 1, {31'h0, st[`BCX_ST_SUSP]});
    cmp("accept", 3, ev);
    rd(`BCX_REG_COUNT, rv);
    cmp("suspend count", 4, rv);
    rd(`BCX_REG_ACC_LO, rv);
    cmp("suspend acc", q[0] * q[1], rv);
    $display("mac done");
    close_out();
  end
endmodule
`default_nettype wire
